// File: core/wheel_drive.sv
// What this block does
// - Two encoder inputs, independent counts per wheel
// - Setup command encoder option starts counting
// - Counting command turns counting on or off
// - Rotate stops motors at angle pulse count
// - Hold diameter and quarter-turn calibration counts
// - Ramp defaults 1, larger ramps faster
// - Advance ramps up, approach speed near target
// - Nonzero final speed applies very near target
// - Slow the leading wheel until counts match
// - Reduction is speed over divisor, default 2
// - Diameter calibration is 8-bit, max 255
// - Prescale divisor drops pulses before counting
`timescale 1ns/10ps
`default_nettype none
`include "wheel_drive_defines.svh"

module wheel_drive
#(
    parameter int RAMP_CYCLES = `RAMP_CYCLES
)
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    // Encoders
    input wire logic left_pulse,
    input wire logic right_pulse,
    // Register port
    input wire logic [3:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    // Motors
    output wheel_drive_pkg::speed_t left_speed,
    output wheel_drive_pkg::speed_t right_speed,
    output logic left_reverse,
    output logic right_reverse,
    output logic moving
);
    import wheel_drive_pkg::*;

    logic count_en_ff;
    speed_t body_width_ff;
    speed_t quarter_ff;
    speed_t accel_ff;
    speed_t normal_ff;
    speed_t approach_ff;
    speed_t final_ff;
    speed_t balance_ff;
    speed_t prescale_ff;
    move_state_t state_ff;
    count_t target_ff;
    count_t left_cnt_ff;
    count_t right_cnt_ff;
    speed_t left_pre_ff;
    speed_t right_pre_ff;
    logic left_prev_ff;
    logic right_prev_ff;
    speed_t ramp_ff;
    logic [15:0] tick_cnt_ff;
    logic [1:0] dir_ff;
    speed_t left_speed_ff;
    speed_t right_speed_ff;
    logic [15:0] rdata_ff;
    logic moving_ff;

    function automatic logic wr_hit(input logic [3:0] ofs);
        wr_hit = reg_wr && (reg_addr == ofs);
    endfunction

    // Configuration registers
    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            body_width_ff <= `RST_BODY_WIDTH;
            quarter_ff <= `RST_QUARTER;
            accel_ff <= `RST_ACCEL;
            normal_ff <= `RST_NORMAL_SPEED;
            approach_ff <= `RST_APPROACH;
            final_ff <= `RST_FINAL;
            balance_ff <= `RST_BALANCE;
            prescale_ff <= `RST_PRESCALE;
        end
        else
        begin
            if (wr_hit(`OFS_BODY_WIDTH))
                body_width_ff <= reg_wdata[7:0];
            if (wr_hit(`OFS_QUARTER))
                quarter_ff <= reg_wdata[7:0];
            if (wr_hit(`OFS_ACCEL))
                accel_ff <= (reg_wdata[7:0] == 8'h00) ? 8'h01 : reg_wdata[7:0];
            if (wr_hit(`OFS_NORMAL_SPEED))
                normal_ff <= reg_wdata[7:0];
            if (wr_hit(`OFS_APPROACH))
                approach_ff <= reg_wdata[7:0];
            if (wr_hit(`OFS_FINAL))
                final_ff <= reg_wdata[7:0];
            if (wr_hit(`OFS_BALANCE))
                balance_ff <= (reg_wdata[7:0] == 8'h00) ? 8'h01 : reg_wdata[7:0];
            if (wr_hit(`OFS_PRESCALE))
                prescale_ff <= (reg_wdata[7:0] == 8'h00) ? 8'h01 : reg_wdata[7:0];
        end
    end

    // Counting enable
    always_ff @(posedge sys_clk)
    begin
        if (reset)
            count_en_ff <= 1'b0;
        else if (wr_hit(`OFS_SETUP))
            count_en_ff <= reg_wdata[`SETUP_ENC_BIT];
        else if (wr_hit(`OFS_COUNT_EN))
            count_en_ff <= reg_wdata != 16'h0000;
    end

    // Pulse edges
    logic left_edge;
    logic right_edge;
    logic move_start;
    assign left_edge = left_pulse && !left_prev_ff;
    assign right_edge = right_pulse && !right_prev_ff;
    assign move_start = count_en_ff && (wr_hit(`OFS_ADVANCE) || wr_hit(`OFS_ROTATE));

    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            left_prev_ff <= 1'b0;
            right_prev_ff <= 1'b0;
        end
        else
        begin
            left_prev_ff <= left_pulse;
            right_prev_ff <= right_pulse;
        end
    end

    // Prescaled wheel counters
    always_ff @(posedge sys_clk)
    begin
        if (reset || move_start)
        begin
            left_pre_ff <= 8'h00;
            right_pre_ff <= 8'h00;
            left_cnt_ff <= 16'h0000;
            right_cnt_ff <= 16'h0000;
        end
        else if (count_en_ff)
        begin
            if (left_edge)
            begin
                if (left_pre_ff + 8'h01 >= prescale_ff)
                begin
                    left_pre_ff <= 8'h00;
                    left_cnt_ff <= left_cnt_ff + 16'h0001;
                end
                else
                    left_pre_ff <= left_pre_ff + 8'h01;
            end
            if (right_edge)
            begin
                if (right_pre_ff + 8'h01 >= prescale_ff)
                begin
                    right_pre_ff <= 8'h00;
                    right_cnt_ff <= right_cnt_ff + 16'h0001;
                end
                else
                    right_pre_ff <= right_pre_ff + 8'h01;
            end
        end
    end

    // Progress and remaining distance
    count_t progress;
    count_t remaining;
    logic done;
    assign progress = (left_cnt_ff < right_cnt_ff) ? left_cnt_ff : right_cnt_ff;
    assign done = progress >= target_ff;
    assign remaining = done ? 16'h0000 : target_ff - progress;

    // Movement sequencer
    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            state_ff <= MV_IDLE;
            target_ff <= 16'h0000;
            dir_ff <= 2'b00;
        end
        else if (move_start && wr_hit(`OFS_ADVANCE))
        begin
            state_ff <= MV_ADVANCE;
            target_ff <= 16'((reg_wdata[7:0] * body_width_ff) >> 3);
            dir_ff <= {2{reg_wdata[`ROT_DIR_BIT]}};
        end
        else if (move_start)
        begin
            state_ff <= MV_ROTATE;
            target_ff <= 16'((reg_wdata[7:0] * quarter_ff) / `DEG_PER_QUARTER);
            dir_ff <= {reg_wdata[`ROT_DIR_BIT], !reg_wdata[`ROT_DIR_BIT]};
        end
        else
        begin
            unique case (state_ff)
                MV_ADVANCE, MV_ROTATE:
                    if (done || !count_en_ff)
                        state_ff <= MV_IDLE;
                default:
                    state_ff <= MV_IDLE;
            endcase
        end
    end
    always_ff @(posedge sys_clk)
        moving_ff <= !reset && (move_start || (moving_ff && !done && count_en_ff));

    // Ramp timer and level
    logic ramp_tick;
    assign ramp_tick = tick_cnt_ff == 16'(RAMP_CYCLES - 1);
    always_ff @(posedge sys_clk)
    begin
        if (reset || ramp_tick)
            tick_cnt_ff <= 16'h0000;
        else
            tick_cnt_ff <= tick_cnt_ff + 16'h0001;
    end

    // Speed goal with approach stages
    speed_t goal;
    always_comb
    begin
        goal = normal_ff;
        if (state_ff == MV_IDLE)
            goal = 8'h00;
        else if (final_ff != 8'h00 && remaining <= `VERY_NEAR_PULSES)
            goal = final_ff;
        else if (remaining <= `NEAR_PULSES)
            goal = approach_ff;
    end

    always_ff @(posedge sys_clk)
    begin
        if (reset || move_start || state_ff == MV_IDLE)
            ramp_ff <= 8'h00;
        else if (ramp_tick)
        begin
            if (ramp_ff < goal)
                ramp_ff <= (goal - ramp_ff > accel_ff) ? ramp_ff + accel_ff : goal;
            else if (ramp_ff > goal)
                ramp_ff <= (ramp_ff - goal > accel_ff) ? ramp_ff - accel_ff : goal;
        end
    end

    // Balance correction on leading wheel
    speed_t cut;
    assign cut = ramp_ff / balance_ff;

    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            left_speed_ff <= 8'h00;
            right_speed_ff <= 8'h00;
        end
        else
        begin
            left_speed_ff <= (left_cnt_ff > right_cnt_ff) ? ramp_ff - cut : ramp_ff;
            right_speed_ff <= (right_cnt_ff > left_cnt_ff) ? ramp_ff - cut : ramp_ff;
        end
    end

    // Register read
    always_ff @(posedge sys_clk)
    begin
        if (reset)
            rdata_ff <= 16'h0000;
        else if (reg_rd)
        begin
            unique case (reg_addr)
                `OFS_COUNT_EN: rdata_ff <= {15'h0000, count_en_ff};
                `OFS_BODY_WIDTH: rdata_ff <= {8'h00, body_width_ff};
                `OFS_QUARTER: rdata_ff <= {8'h00, quarter_ff};
                `OFS_ACCEL: rdata_ff <= {8'h00, accel_ff};
                `OFS_NORMAL_SPEED: rdata_ff <= {8'h00, normal_ff};
                `OFS_APPROACH: rdata_ff <= {8'h00, approach_ff};
                `OFS_FINAL: rdata_ff <= {8'h00, final_ff};
                `OFS_BALANCE: rdata_ff <= {8'h00, balance_ff};
                `OFS_PRESCALE: rdata_ff <= {8'h00, prescale_ff};
                `OFS_STATUS: rdata_ff <= {14'h0000, state_ff};
                `OFS_LEFT_COUNT: rdata_ff <= left_cnt_ff;
                `OFS_RIGHT_COUNT: rdata_ff <= right_cnt_ff;
                default: rdata_ff <= 16'h0000;
            endcase
        end
    end

    assign reg_rdata = rdata_ff;
    assign left_speed = left_speed_ff;
    assign right_speed = right_speed_ff;
    assign left_reverse = dir_ff[1];
    assign right_reverse = dir_ff[0];
    assign moving = moving_ff;

    // Checks
    AST_PRESCALE_ONE: assert property (@(posedge sys_clk) disable iff (reset)
        (prescale_ff == 8'h01 && count_en_ff && left_edge && !move_start)
        |=> left_cnt_ff == $past(left_cnt_ff) + 16'h0001)
        else $error("Unscaled pulse not counted");
    AST_NO_COUNT_OFF: assert property (@(posedge sys_clk) disable iff (reset)
        (!count_en_ff && !move_start) |=> $stable(left_cnt_ff) && $stable(right_cnt_ff))
        else $error("Counting while disabled");
    AST_COUNT_CMD: assert property (@(posedge sys_clk) disable iff (reset)
        (reg_wr && reg_addr == `OFS_COUNT_EN) |=> count_en_ff == $past(reg_wdata != 16'h0000))
        else $error("Counting command ignored");
    AST_SETUP_ENC: assert property (@(posedge sys_clk) disable iff (reset)
        (reg_wr && reg_addr == `OFS_SETUP) |=> count_en_ff == $past(reg_wdata[`SETUP_ENC_BIT]))
        else $error("Setup encoder option ignored");
    AST_STOP_AT_TARGET: assert property (@(posedge sys_clk) disable iff (reset)
        (state_ff != MV_IDLE && done && !move_start) |=> state_ff == MV_IDLE ##2 left_speed == 8'h00)
        else $error("Motion not halted at target");
    AST_FINAL_STAGE: assert property (@(posedge sys_clk) disable iff (reset)
        (state_ff != MV_IDLE && final_ff != 8'h00 && remaining <= `VERY_NEAR_PULSES) |-> goal == final_ff)
        else $error("Final approach speed not used");
    AST_APPROACH: assert property (@(posedge sys_clk) disable iff (reset)
        (state_ff != MV_IDLE && remaining <= `NEAR_PULSES
        && (final_ff == 8'h00 || remaining > `VERY_NEAR_PULSES)) |-> goal == approach_ff)
        else $error("Approach speed not used");
    AST_BALANCE: assert property (@(posedge sys_clk) disable iff (reset)
        (left_cnt_ff > right_cnt_ff) |=> left_speed_ff == $past(ramp_ff) - $past(cut))
        else $error("Leading wheel not slowed");
    AST_RAMP_STEP: assert property (@(posedge sys_clk) disable iff (reset)
        (state_ff != MV_IDLE && !move_start && ramp_tick && ramp_ff < goal)
        |=> ramp_ff > $past(ramp_ff))
        else $error("Ramp did not advance");
endmodule

`default_nettype wire

// File: core/wheel_drive_defines.svh
`ifndef WHEEL_DRIVE_DEFINES_SVH
`define WHEEL_DRIVE_DEFINES_SVH

// Register offsets (word index = byte address)
`define OFS_COUNT_EN 4'h0
`define OFS_BODY_WIDTH 4'h1
`define OFS_QUARTER 4'h2
`define OFS_ACCEL 4'h3
`define OFS_NORMAL_SPEED 4'h4
`define OFS_APPROACH 4'h5
`define OFS_FINAL 4'h6
`define OFS_BALANCE 4'h7
`define OFS_PRESCALE 4'h8
`define OFS_SETUP 4'h9
`define OFS_ADVANCE 4'ha
`define OFS_ROTATE 4'hb
`define OFS_STATUS 4'hc
`define OFS_LEFT_COUNT 4'hd
`define OFS_RIGHT_COUNT 4'he

// Field positions
`define SETUP_ENC_BIT 0
`define ROT_DIR_BIT 15

// Reset values
`define RST_ACCEL 8'h01
`define RST_BALANCE 8'h02
`define RST_PRESCALE 8'h01
`define RST_BODY_WIDTH 8'h1e
`define RST_QUARTER 8'h1e
`define RST_NORMAL_SPEED 8'hc8
`define RST_APPROACH 8'h40
`define RST_FINAL 8'h00

// Approach thresholds in pulses
`define NEAR_PULSES 16'h0010
`define VERY_NEAR_PULSES 16'h0004

// Degrees in one quarter turn
`define DEG_PER_QUARTER 16'h005a

// Ramp step interval: 1 ms at 20 MHz
`define RAMP_TIME_NS 1000000
`define CLK_PERIOD_NS 50
`define RAMP_CYCLES (`RAMP_TIME_NS / `CLK_PERIOD_NS)

`endif

// File: core/wheel_drive_pkg.sv
package wheel_drive_pkg;
    typedef enum logic [1:0] {
        MV_IDLE = 2'b00,
        MV_ADVANCE = 2'b01,
        MV_ROTATE = 2'b10
    } move_state_t;
    typedef logic [7:0] speed_t;
    typedef logic [15:0] count_t;
endpackage

// File: tb/wheel_drive_tb.sv
`timescale 1ns/10ps
`default_nettype none

module wheel_drive_tb;
    import wheel_drive_pkg::*;
    logic sys_clk = 1'b0;
    logic reset = 1'b1;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic go_r = 1'b1;
    logic [3:0] reg_addr = 4'h0;
    logic [15:0] reg_wdata = 16'h0000;
    logic [15:0] reg_rdata;
    logic [15:0] sent_l;
    speed_t left_speed;
    speed_t right_speed;
    logic left_reverse;
    logic right_reverse;
    logic moving;
    logic left_pulse;
    logic right_pulse;
    int mismatches = 0;
    int samples_checked = 0;
    logic [19:0] rows [15] = '{20'h00000, 20'h1001e, 20'h2001e, 20'h30001, 20'h400c8,
        20'h50040, 20'h60000, 20'h70002, 20'h80001, 20'h90000, 20'ha0000, 20'hb0000,
        20'hc0000, 20'hd0000, 20'hf0000};

    wheel_drive #(.RAMP_CYCLES(4)) wheel_drive_i (.sys_clk(sys_clk), .reset(reset),
        .left_pulse(left_pulse), .right_pulse(right_pulse), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .left_speed(left_speed), .right_speed(right_speed), .left_reverse(left_reverse),
        .right_reverse(right_reverse), .moving(moving));
    wheel_pulse_source #(.HALF(16)) wheel_pulse_source_i (.sys_clk(sys_clk),
        .reset(reset), .run(moving), .pulse(left_pulse), .sent(sent_l));
    wheel_pulse_source #(.HALF(16)) wheel_pulse_source_r_i (.sys_clk(sys_clk),
        .reset(reset), .run(moving && go_r), .pulse(right_pulse), .sent());

    initial
    begin
        forever #25 sys_clk = ~sys_clk;
    end

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, input logic [15:0] exp);
        @(posedge sys_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        check(reg_rdata, exp);
    endtask

    task automatic at_pulse(input int n);
        int k;
        k = 0;
        while (sent_l < 16'(n) && k < 20000)
        begin
            @(posedge sys_clk);
            k++;
        end
        if (k >= 20000)
        begin
            mismatches++;
            $display("wrong value at %0t: pulse wait limit", $time);
        end
        repeat (12) @(posedge sys_clk);
        #1;
    endtask

    task automatic wait_stop();
        int k;
        k = 0;
        while (moving === 1'b1 && k < 20000)
        begin
            @(posedge sys_clk);
            k++;
        end
        if (k >= 20000)
        begin
            mismatches++;
            $display("wrong value at %0t: stop wait limit", $time);
        end
    endtask

    task automatic wrap_up();
        $display("mismatches %0d samples_checked %0d", mismatches, samples_checked);
        if (mismatches == 0 && samples_checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    initial
    begin
        repeat (4) @(posedge sys_clk);
        reset <= 1'b0;
        foreach (rows[i])
            rd(rows[i][19:16], rows[i][15:0]);
        wr(4'h1, 16'h01ff);
        rd(4'h1, 16'h00ff);
        wr(4'h3, 16'h0000);
        rd(4'h3, 16'h0001);
        // Move refused while counting is off
        wr(4'ha, 16'h0008);
        repeat (3) @(posedge sys_clk);
        #1;
        check({15'h0000, moving}, 16'h0000);
        wr(4'h1, 16'h00c8);
        wr(4'h4, 16'h0020);
        wr(4'h5, 16'h0010);
        wr(4'h6, 16'h0008);
        wr(4'h9, 16'h0001);
        rd(4'h0, 16'h0001);
        // Speed profile of a 200-pulse advance
        wr(4'ha, 16'h0008);
        repeat (12) @(posedge sys_clk);
        #1;
        check({15'h0000, left_speed < 8'h08}, 16'h0001);
        wr(4'h3, 16'h00ff);
        at_pulse(100);
        check({8'h00, left_speed}, 16'h0020);
        rd(4'hd, 16'h0064);
        at_pulse(190);
        check({8'h00, left_speed}, 16'h0010);
        at_pulse(198);
        check({8'h00, left_speed}, 16'h0008);
        wait_stop();
        rd(4'hd, 16'h00c8);
        rd(4'he, 16'h00c8);
        // Right wheel stalls, left leads
        wr(4'ha, 16'h0008);
        at_pulse(5);
        go_r = 1'b0;
        at_pulse(8);
        check({8'h00, left_speed}, 16'h0010);
        check({8'h00, right_speed}, 16'h0020);
        wr(4'h7, 16'h0004);
        repeat (12) @(posedge sys_clk);
        #1;
        check({8'h00, left_speed}, 16'h0018);
        go_r = 1'b1;
        wr(4'h0, 16'h0000);
        repeat (2) @(posedge sys_clk);
        #1;
        check({15'h0000, moving}, 16'h0000);
        // Prescale by two
        wr(4'h0, 16'h0001);
        wr(4'h8, 16'h0002);
        wr(4'ha, 16'h0008);
        at_pulse(8);
        rd(4'hd, 16'h0004);
        wr(4'h0, 16'h0000);
        wr(4'h8, 16'h0001);
        // Quarter turn of 20 pulses
        wr(4'h2, 16'h0014);
        wr(4'h0, 16'h0001);
        wr(4'hb, 16'h805a);
        repeat (4) @(posedge sys_clk);
        #1;
        check({15'h0000, left_reverse ^ right_reverse}, 16'h0001);
        wait_stop();
        rd(4'hd, 16'h0014);
        // Second reset in mid-run
        wr(4'ha, 16'h0008);
        at_pulse(3);
        @(posedge sys_clk);
        reset <= 1'b1;
        repeat (4) @(posedge sys_clk);
        reset <= 1'b0;
        #1;
        check({15'h0000, moving}, 16'h0000);
        check({8'h00, left_speed}, 16'h0000);
        rd(4'h0, 16'h0000);
        rd(4'h8, 16'h0001);
        wrap_up();
    end

    initial
    begin
        repeat (40000) @(posedge sys_clk);
        mismatches++;
        wrap_up();
    end
endmodule

`default_nettype wire

// File: tb/wheel_pulse_source.sv
`timescale 1ns/10ps
`default_nettype none

// Encoder stand-in: square wave while run, parked low otherwise
module wheel_pulse_source
#(
    parameter int HALF = 16
)
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    // Control
    input wire logic run,
    // Encoder line and rising edges sent since run rose
    output logic pulse,
    output logic [15:0] sent
);
    logic [7:0] phase_ff;

    always_ff @(posedge sys_clk)
    begin
        if (reset || !run)
        begin
            phase_ff <= 8'h00;
            pulse <= 1'b0;
            sent <= 16'h0000;
        end
        else if (phase_ff == 8'(HALF - 1))
        begin
            phase_ff <= 8'h00;
            pulse <= !pulse;
            if (!pulse)
                sent <= sent + 16'h0001;
        end
        else
            phase_ff <= phase_ff + 8'h01;
    end
endmodule

`default_nettype wire
